//--- spm_pkg.sv
package spm_pkg;
    // Register byte addresses (low address byte only)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] DATA_OFS = 8'h08;
    // Control field positions
    localparam int IRQEN_BIT = 7;
    localparam int PORTEN_BIT = 6;
    localparam int BYPASS_BIT = 5;
    localparam int CSEL_BIT = 4;
    localparam int CLOCK_IDLE_LEVEL_BIT = 3;
    localparam int CLOCK_CAPTURE_PHASE_BIT = 2;
    localparam int RATE_LSB = 0;
    // Status field positions
    localparam int DONE_BIT = 7;
    localparam int WRITE_COLLISION_FLAG_BIT = 6;
    localparam int OVR_BIT = 5;
    localparam int MASTER_FAULT_FLAG_BIT = 4;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // Edges in one byte: two per bit
    localparam logic [3:0] LAST_EDGE = 4'hf;

    typedef logic [31:0] spm_word_t;
    typedef enum {SPM_IDLE, SPM_RUN} spm_state_e;

    // Half period of the serial clock in system clocks
    function automatic logic [4:0] spm_half(input logic bypass, input logic [1:0] rate);
        logic [4:0] h;
        h = 5'h01 << rate;
        return bypass ? h : 5'(h << 1);
    endfunction
endpackage

//--- spm_sync.sv
`timescale 1ns/1ps
module spm_sync #(
    parameter int W = 4
) (
    input wire logic clk, // System clock
    input wire logic rst_b, // Sync reset, active low
    input wire logic ce, // Clock enable
    input wire logic [W-1:0] din, // Asynchronous pin levels
    output logic [W-1:0] dout // Filtered levels
);
    import spm_pkg::*;
    if (W < 1) $error("spm_sync: W must be at least 1");

    logic [W-1:0] s1_ff, s2_ff, s3_ff, out_ff;
    logic [W-1:0] nxt_out;

    // Accept a change only once stages two and three agree
    always_comb
    begin
        for (int i = 0; i < W; i++)
            nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            out_ff <= '0;
        end
        else if (ce)
        begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= nxt_out;
        end
    end

    assign dout = out_ff;
endmodule

//--- spm_baud.sv
`timescale 1ns/1ps
module spm_baud #(
    parameter int CW = 5
) (
    input wire logic clk, // System clock
    input wire logic rst_b, // Sync reset, active low
    input wire logic ce, // Clock enable
    input wire logic run, // Count while high
    input wire logic [4:0] half, // Half period in clocks
    output logic tick // One-cycle edge strobe
);
    import spm_pkg::*;
    if (CW < 5) $error("spm_baud: CW too small for half period");

    logic [CW-1:0] cnt_ff, nxt_cnt;

    // Counter restarts whenever the transfer is not running
    always_comb
    begin
        tick = run && (cnt_ff == CW'(half - 5'h01));
        if (!run || tick)
            nxt_cnt = '0;
        else
            nxt_cnt = cnt_ff + CW'(1);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            cnt_ff <= '0;
        else if (ce)
            cnt_ff <= nxt_cnt;
    end
endmodule

//--- spm_core.sv
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
// Function
// R1: Four clock modes from idle level, phase
// R2: Serial clock idles at idle level bit
// R3: Phase 0 captures first edge, 1 second
// R4: Disable port before changing idle level
// R5: Slave uses same clock settings as master
// R6: Master with select low sets fault flag
// R7: Fault clears port enable and controller select
// R8: Fault clears by status read, control write
// R9: Fault blocks setting enable/select outside sequence
// R10: Hold select high during fault clearing
// R11: Byte before done cleared sets overrun
// R12: Overrun keeps first byte, later ones lost
// R13: Status register read clears overrun
// R14: Clear done flag before next transfer ends
// R15: Data write while busy discarded, sets collision
// R16: Collision flag never requests an interrupt
// R17: Received byte buffered, read synchronously
// R18: Interrupt enable gates done, fault, overrun
// R19: Port enable reset low, connects pins
// R20: Bit 5 bypasses divide-by-two, master only
// R21: Bit 4 selects controller, turns pins
// R22: Collision clears by status read, data access
module spm_core (
    input wire logic clk, // System clock, 25 MHz
    input wire logic rst_b, // Sync reset, active low
    input wire logic ce, // Clock enable, freezes state
    input wire logic hsel, // AHB slave select
    input wire spm_pkg::spm_word_t haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire spm_pkg::spm_word_t hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // AHB slave ready
    output spm_pkg::spm_word_t hrdata, // AHB read data
    output logic hresp, // AHB response, always OKAY
    input wire logic sckIn, // Serial clock pin in
    output logic sckOut, // Serial clock pin out
    output logic sckOe_b, // Serial clock drive, low drives
    input wire logic mosiIn, // Controller-out pin in
    output logic mosiOut, // Controller-out pin out
    output logic mosiOe_b, // Controller-out drive, low drives
    input wire logic misoIn, // Controller-in pin in
    output logic misoOut, // Controller-in pin out
    output logic misoOe_b, // Controller-in drive, low drives
    input wire logic ssIn_b, // Slave select pin, active low
    output logic irqReq, // Interrupt request level
    output logic portActive // Serial alternate functions on
);
    import spm_pkg::*;

    logic [3:0] pinS;
    logic sckS, mosiS, misoS, ssS_b, tick;

    // Pins arrive from outside the clock domain
    spm_sync #(.W(4)) uSync (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .din({ssIn_b, misoIn, mosiIn, sckIn}),
        .dout(pinS)
    );
    assign sckS = pinS[0];
    assign mosiS = pinS[1];
    assign misoS = pinS[2];
    assign ssS_b = pinS[3];

    logic [7:0] ctrl_ff, nxt_ctrl;
    logic done_ff, write_collision_flag_ff, ovr_ff, master_fault_flag_ff;
    logic nxt_done, nxt_write_collision_flag, nxt_ovr, nxt_master_fault_flag;
    logic doneArm_ff, wcolArm_ff, modfArm_ff;
    logic nxt_doneArm, nxt_wcolArm, nxt_modfArm;
    logic [7:0] rxBuf_ff, txSh_ff, rxSh_ff;
    logic [7:0] nxt_rxBuf, nxt_txSh, nxt_rxSh;
    logic outBit_ff, sckLvl_ff, sckPrev_ff;
    logic nxt_outBit, nxt_sckLvl, nxt_sckPrev;
    logic [3:0] edgeCnt_ff, nxt_edgeCnt;
    spm_state_e state_ff, nxt_state;
    logic aValid_ff, aWrite_ff, nxt_aValid, nxt_aWrite;
    logic [7:0] aAddr_ff, nxt_aAddr;
    spm_word_t hrdata_ff, nxt_hrdata;

    logic controller, portEn, clock_idle_level, clock_capture_phase, busy;
    logic busRd, rdStat, rdData, wrCtrl, wrData;
    logic edgeEv, leading, inBit, byteDone;
    logic [7:0] stat, wByte;

    assign controller = ctrl_ff[CSEL_BIT];
    assign portEn = ctrl_ff[PORTEN_BIT];
    assign clock_idle_level = ctrl_ff[CLOCK_IDLE_LEVEL_BIT];
    assign clock_capture_phase = ctrl_ff[CLOCK_CAPTURE_PHASE_BIT];
    assign busy = (state_ff == SPM_RUN);
    assign stat = {done_ff, write_collision_flag_ff, ovr_ff, master_fault_flag_ff, 4'h0};
    assign wByte = hwdata[7:0];

    // Divider runs only for a controller transfer, so bit 5 has no slave effect
    spm_baud #(.CW(5)) uBaud (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .run(busy && controller),
        .half(spm_half(ctrl_ff[BYPASS_BIT], ctrl_ff[RATE_LSB +: 2])), // R20
        .tick(tick)
    );

    // Read side effects act in the address phase, writes in the data phase
    always_comb
    begin
        busRd = hsel && htrans[1] && hready && !hwrite;
        rdStat = busRd && (haddr[7:0] == STAT_OFS);
        rdData = busRd && (haddr[7:0] == DATA_OFS);
        wrCtrl = aValid_ff && aWrite_ff && (aAddr_ff == CTRL_OFS);
        wrData = aValid_ff && aWrite_ff && (aAddr_ff == DATA_OFS);
        nxt_aValid = hsel && htrans[1] && hready;
        nxt_aWrite = hwrite;
        nxt_aAddr = haddr[7:0];
        nxt_hrdata = hrdata_ff;
        if (busRd)
        begin
            case (haddr[7:0])
                CTRL_OFS: nxt_hrdata = {24'h000000, ctrl_ff};
                STAT_OFS: nxt_hrdata = {24'h000000, stat};
                DATA_OFS: nxt_hrdata = {24'h000000, rxBuf_ff}; // R17
                default: nxt_hrdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            aValid_ff <= 1'b0;
            aWrite_ff <= 1'b0;
            aAddr_ff <= 8'h00;
            hrdata_ff <= 32'h00000000;
        end
        else if (ce)
        begin
            aValid_ff <= nxt_aValid;
            aWrite_ff <= nxt_aWrite;
            aAddr_ff <= nxt_aAddr;
            hrdata_ff <= nxt_hrdata;
        end
    end

    // Transfer engine, flags and control register
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_done = done_ff;
        nxt_write_collision_flag = write_collision_flag_ff;
        nxt_ovr = ovr_ff;
        nxt_master_fault_flag = master_fault_flag_ff;
        nxt_doneArm = doneArm_ff;
        nxt_wcolArm = wcolArm_ff;
        nxt_modfArm = modfArm_ff;
        nxt_rxBuf = rxBuf_ff;
        nxt_txSh = txSh_ff;
        nxt_rxSh = rxSh_ff;
        nxt_outBit = outBit_ff;
        nxt_sckLvl = sckLvl_ff;
        nxt_sckPrev = sckS;
        nxt_edgeCnt = edgeCnt_ff;
        nxt_state = state_ff;
        byteDone = 1'b0;
        leading = !edgeCnt_ff[0];
        inBit = controller ? misoS : mosiS; // R21
        // A slave edge is any accepted change of the clock pin while enabled and selected
        if (controller)
            edgeEv = busy && tick;
        else
            edgeEv = portEn && !ssS_b && (sckS != sckPrev_ff);

        // Clearing sequences; later set terms override
        if (rdStat && done_ff)
            nxt_doneArm = 1'b1;
        if (rdStat && write_collision_flag_ff)
            nxt_wcolArm = 1'b1;
        if (rdStat && master_fault_flag_ff)
            nxt_modfArm = 1'b1;
        if (doneArm_ff && (rdData || wrData))
        begin
            nxt_done = 1'b0;
            nxt_doneArm = 1'b0;
        end
        if (wcolArm_ff && (rdData || wrData)) // R22
        begin
            nxt_write_collision_flag = 1'b0;
            nxt_wcolArm = 1'b0;
        end
        if (rdStat)
            nxt_ovr = 1'b0; // R13

        // Control write; a pending fault keeps enable and select low
        if (wrCtrl)
        begin
            if (modfArm_ff)
            begin
                nxt_ctrl = wByte; // R8
                nxt_master_fault_flag = 1'b0;
                nxt_modfArm = 1'b0;
            end
            else if (master_fault_flag_ff)
            begin
                nxt_ctrl = wByte;
                nxt_ctrl[PORTEN_BIT] = portEn; // R9
                nxt_ctrl[CSEL_BIT] = controller; // R9
            end
            else
                nxt_ctrl = wByte;
        end

        // Data write: discarded while a byte is on the wire
        if (wrData)
        begin
            if (busy)
                nxt_write_collision_flag = 1'b1; // R15
            else
            begin
                if (clock_capture_phase)
                    nxt_txSh = wByte;
                else
                begin
                    nxt_outBit = wByte[7];
                    nxt_txSh = {wByte[6:0], 1'b0};
                end
                if (controller && portEn)
                begin
                    nxt_state = SPM_RUN;
                    nxt_edgeCnt = 4'h0;
                end
            end
        end

        // One clock edge of the byte: sample or drive by phase
        if (edgeEv)
        begin
            if (leading != clock_capture_phase) // R3
                nxt_rxSh = {rxSh_ff[6:0], inBit};
            if ((leading && clock_capture_phase) || (!leading && !clock_capture_phase && edgeCnt_ff != LAST_EDGE)) // R1
            begin
                nxt_outBit = txSh_ff[7];
                nxt_txSh = {txSh_ff[6:0], 1'b0};
            end
            nxt_sckLvl = !sckLvl_ff;
            if (edgeCnt_ff == LAST_EDGE)
            begin
                byteDone = 1'b1;
                nxt_state = SPM_IDLE;
                nxt_edgeCnt = 4'h0;
            end
            else
            begin
                nxt_state = SPM_RUN;
                nxt_edgeCnt = edgeCnt_ff + 4'h1;
            end
        end

        // Completed byte; an uncleared done flag means overrun
        if (byteDone)
        begin
            if (done_ff && nxt_done)
                nxt_ovr = 1'b1; // R11
            else
            begin
                nxt_rxBuf = nxt_rxSh; // R12
                nxt_done = 1'b1;
            end
        end

        // Slave deselect or disabled port abandons a partial byte
        if (!portEn || (!controller && ssS_b))
        begin
            nxt_state = SPM_IDLE;
            nxt_edgeCnt = 4'h0;
        end
        if (nxt_state == SPM_IDLE || !controller)
            nxt_sckLvl = clock_idle_level; // R2

        // Controller sees select low: fault wins over any write
        if (controller && portEn && !ssS_b)
        begin
            nxt_master_fault_flag = 1'b1; // R6
            nxt_ctrl[PORTEN_BIT] = 1'b0; // R7
            nxt_ctrl[CSEL_BIT] = 1'b0; // R7
            nxt_state = SPM_IDLE;
            nxt_edgeCnt = 4'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ctrl_ff <= CTRL_RST; // R19
            done_ff <= 1'b0;
            write_collision_flag_ff <= 1'b0;
            ovr_ff <= 1'b0;
            master_fault_flag_ff <= 1'b0;
            doneArm_ff <= 1'b0;
            wcolArm_ff <= 1'b0;
            modfArm_ff <= 1'b0;
            rxBuf_ff <= BYTE_RST;
            txSh_ff <= BYTE_RST;
            rxSh_ff <= BYTE_RST;
            outBit_ff <= 1'b0;
            sckLvl_ff <= 1'b0;
            sckPrev_ff <= 1'b0;
            edgeCnt_ff <= 4'h0;
            state_ff <= SPM_IDLE;
        end
        else if (ce)
        begin
            ctrl_ff <= nxt_ctrl;
            done_ff <= nxt_done;
            write_collision_flag_ff <= nxt_write_collision_flag;
            ovr_ff <= nxt_ovr;
            master_fault_flag_ff <= nxt_master_fault_flag;
            doneArm_ff <= nxt_doneArm;
            wcolArm_ff <= nxt_wcolArm;
            modfArm_ff <= nxt_modfArm;
            rxBuf_ff <= nxt_rxBuf;
            txSh_ff <= nxt_txSh;
            rxSh_ff <= nxt_rxSh;
            outBit_ff <= nxt_outBit;
            sckLvl_ff <= nxt_sckLvl;
            sckPrev_ff <= nxt_sckPrev;
            edgeCnt_ff <= nxt_edgeCnt;
            state_ff <= nxt_state;
        end
    end

    // Bus answers with no wait state while enabled
    assign hreadyout = ce;
    assign hrdata = hrdata_ff;
    assign hresp = 1'b0;

    // Collision flag deliberately left out of the request
    assign irqReq = ctrl_ff[IRQEN_BIT] && (done_ff || master_fault_flag_ff || ovr_ff); // R18 R16

    // Pin directions follow enable and controller select
    assign portActive = portEn; // R19
    assign sckOut = sckLvl_ff;
    assign sckOe_b = !(portEn && controller); // R21
    assign mosiOut = outBit_ff;
    assign mosiOe_b = !(portEn && controller); // R21
    assign misoOut = outBit_ff;
    assign misoOe_b = !(portEn && !controller && !ssS_b); // R21
endmodule

//--- spm_assertions.sv
`timescale 1ns/1ps
// Port-level checker for the serial block
module spm_assertions (
    input wire logic clk, // System clock
    input wire logic rst_b, // Sync reset, active low
    input wire logic ce, // Clock enable
    input wire logic hreadyout, // Slave ready
    input wire spm_pkg::spm_word_t hrdata, // Read data
    input wire logic ssIn_b, // Select pin
    input wire logic sckOe_b, // Clock drive, low drives
    input wire logic mosiOe_b, // Out-pin drive
    input wire logic misoOe_b, // In-pin drive
    input wire logic irqReq, // Interrupt level
    input wire logic portActive // Port enabled
);
    default clocking cb @(posedge clk);
    endclocking

    chk_ready_zero_wait: assert property (disable iff (!rst_b) hreadyout == ce)
        else $error("ready does not follow clock enable");
    chk_rdata_upper: assert property (disable iff (!rst_b) hrdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_oe_needs_port: assert property (disable iff (!rst_b) !sckOe_b |-> portActive)
        else $error("clock driven while port off");
    chk_data_dirs: assert property (disable iff (!rst_b) sckOe_b == mosiOe_b)
        else $error("out-pin drive differs from clock drive");
    chk_miso_slave: assert property (disable iff (!rst_b) !misoOe_b |-> sckOe_b && portActive)
        else $error("in-pin driven outside slave mode");
    // Filter lag is three to four clocks, so allow a few cycles
    chk_fault_drop: assert property (disable iff (!rst_b)
        (!sckOe_b && !ssIn_b)[*4] |-> ##[0:6] (sckOe_b && !portActive))
        else $error("select low in controller mode kept port on");
    // No disable here: reset itself is the cause
    chk_reset_idle: assert property (!rst_b |=> !portActive && !irqReq && sckOe_b)
        else $error("outputs not idle after reset");
    chk_port_fall_oe: assert property (disable iff (!rst_b)
        $fell(portActive) |-> sckOe_b && mosiOe_b && misoOe_b)
        else $error("pins still driven after port off");

    cov_port_off: cover property (disable iff (!rst_b) $fell(portActive));
    cov_irq: cover property (disable iff (!rst_b) $rose(irqReq));
    cov_slave: cover property (disable iff (!rst_b) !misoOe_b);
endmodule

bind spm_core spm_assertions spm_assertions_inst (.*);

//--- spm_peer.sv
`timescale 1ns/1ps
// External slave on the far side of the link
module spm_peer (
    input wire logic sck, // Clock on the wire
    input wire logic mosi, // Data from controller
    input wire logic sel_b, // Peer select, active low
    input wire logic clock_idle_level, // Idle level, as device
    input wire logic clock_capture_phase, // Capture phase, as device
    input wire logic [7:0] txByte, // Byte to return
    output logic miso, // Data to controller
    output logic [7:0] rxByte // Byte received
);
    logic [7:0] sh;
    // Start values
    initial
    begin
        sh = 8'h00;
        miso = 1'b0;
        rxByte = 8'h00;
    end
    // Load on select
    always @(negedge sel_b)
    begin
        sh = txByte;
        miso = txByte[7];
    end
    // Released line inverts, so a late sample is caught
    always @(posedge sel_b) miso = ~miso;
    // Capture on the phase-chosen edge, shift on the other
    always @(sck)
    begin
        if (!sel_b && ((sck != clock_idle_level) ^ clock_capture_phase))
            rxByte = {rxByte[6:0], mosi};
        else if (!sel_b && clock_capture_phase)
        begin
            miso = sh[7];
            sh = sh << 1;
        end
        else if (!sel_b)
        begin
            sh = sh << 1;
            miso = sh[7];
        end
    end
endmodule

//--- spi_mode_and_error_flags_tb.sv
`timescale 1ns/1ps
module spi_mode_and_error_flags_tb;
    import spm_pkg::*;
    logic clk, rst_b, ce, hsel, hwrite, tbSck, tbMosi, ssIn_b, peerSel_b, rdPend;
    logic hreadyout, hresp, sckOut, sckOe_b, mosiOut, mosiOe_b, misoOut, misoOe_b, peerMiso, irqReq, portActive;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] peerTx, peerRx, cfg, tx, a, b, slvOut;
    spm_word_t haddr, hwdata, hrdata;
    spm_word_t expQ[$];
    int num_errors, checks_done;
    // Wire levels: whoever has the drive enable wins
    wire logic sckW = sckOe_b ? tbSck : sckOut;
    wire logic mosiW = mosiOe_b ? tbMosi : mosiOut;
    wire logic misoW = misoOe_b ? peerMiso : misoOut;

    spm_core spm_core_inst (.clk(clk), .rst_b(rst_b), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .sckIn(sckW), .sckOut(sckOut), .sckOe_b(sckOe_b), .mosiIn(mosiW),
        .mosiOut(mosiOut), .mosiOe_b(mosiOe_b), .misoIn(misoW), .misoOut(misoOut), .misoOe_b(misoOe_b),
        .ssIn_b(ssIn_b), .irqReq(irqReq), .portActive(portActive));
    spm_peer spm_peer_inst (.sck(sckW), .mosi(mosiW), .sel_b(peerSel_b), .clock_idle_level(cfg[3]), .clock_capture_phase(cfg[2]),
        .txByte(peerTx), .miso(peerMiso), .rxByte(peerRx));

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task chk(input spm_word_t got, input spm_word_t exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task end_sim;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One transfer; for a read, d is the expected byte
    task bus(input logic wr, input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, ad};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        if (!wr)
        begin
            expQ.push_back({24'h0, d});
            rdPend <= 1'b1;
        end
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdPend <= 1'b0;
    endtask

    // Bounded wait; the interrupt level marks completion or fault
    task waitIrq;
        int i;
        i = 0;
        while (irqReq !== 1'b1 && i < 2000)
        begin
            @(posedge clk);
            i++;
        end
        chk(32'(irqReq), 32'h1);
    endtask

    // Bench as controller, phase 0; half period 6 clocks clears the filter
    task sendByte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--)
        begin
            tbMosi <= v[i];
            wt(6);
            slvOut = {slvOut[6:0], misoW}; // Slave output, taken before the capture edge
            tbSck <= 1'b1;
            wt(6);
            tbSck <= 1'b0;
        end
        wt(6);
    endtask

    // Read data is taken at the data-phase edge
    always @(posedge clk)
        if (rdPend === 1'b1 && hreadyout === 1'b1)
        begin
            chk(hrdata, expQ.pop_front());
            chk(32'(hresp), 32'h0);
        end

    // Cuts a hang short
    initial
    begin
        #800000;
        num_errors++;
        end_sim;
    end

    initial
    begin
        void'($urandom(32'hdc14cccc));
        {rst_b, hsel, hwrite, tbSck, tbMosi, rdPend} = 6'h0;
        {ce, ssIn_b, peerSel_b} = 3'h7;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        cfg = 8'h00;
        peerTx = 8'h00;
        num_errors = 0;
        checks_done = 0;
        wt(6);
        rst_b <= 1'b1;
        bus(0, CTRL_OFS, CTRL_RST);
        bus(0, STAT_OFS, 8'h00);
        bus(0, 8'h0c, 8'h00);
        // All four clock modes, controller side, with a collision mid-byte; odd modes skip the divide-by-two
        for (int m = 0; m < 4; m++)
        begin
            cfg = 8'hd3 | 8'(m << 2) | 8'((m & 1) << 5);
            peerTx = 8'($urandom);
            tx = 8'($urandom);
            bus(1, CTRL_OFS, cfg);
            wt(2);
            chk(32'(sckOut), 32'(cfg[3]));
            peerSel_b <= 1'b0;
            bus(1, DATA_OFS, tx);
            bus(1, DATA_OFS, ~tx);
            wt(1);
            chk(32'(irqReq), 32'h0);
            waitIrq;
            peerSel_b <= 1'b1;
            chk(32'(sckOut), 32'(cfg[3]));
            chk(32'(peerRx), 32'(tx));
            bus(0, STAT_OFS, 8'hc0);
            bus(0, DATA_OFS, peerTx);
            bus(0, STAT_OFS, 8'h00);
            bus(1, CTRL_OFS, 8'h00);
        end
        // Select pulled low while controller
        bus(1, CTRL_OFS, 8'hd0);
        ssIn_b <= 1'b0;
        waitIrq;
        chk(32'(portActive), 32'h0);
        ssIn_b <= 1'b1;
        wt(8);
        bus(1, CTRL_OFS, 8'hd0);
        bus(0, CTRL_OFS, 8'h80);
        bus(0, STAT_OFS, 8'h10);
        bus(1, CTRL_OFS, 8'h50);
        bus(0, STAT_OFS, 8'h00);
        bus(0, CTRL_OFS, 8'h50);
        // Slave: done cleared in mid-byte, then a byte before done is cleared
        a = 8'($urandom);
        b = 8'($urandom);
        tx = 8'($urandom);
        bus(1, CTRL_OFS, 8'h40);
        bus(1, DATA_OFS, tx);
        ssIn_b <= 1'b0;
        wt(8);
        sendByte(a);
        chk(32'(slvOut), 32'(tx));
        fork
            sendByte(b);
            begin
                wt(30);
                bus(0, STAT_OFS, 8'h80);
                bus(0, DATA_OFS, a);
            end
        join
        sendByte(a);
        ssIn_b <= 1'b1;
        wt(8);
        chk(32'(irqReq), 32'h0);
        bus(0, STAT_OFS, 8'ha0);
        bus(0, DATA_OFS, b);
        bus(0, STAT_OFS, 8'h00);
        end_sim;
    end
endmodule
